// file: design/bvb_pkg.sv
// package for the buck channel four / boost control register bank
// shared offsets, field positions, reset values and encodings
package bvb_pkg;

  // register offsets on the i2c register map
  localparam logic [7:0] BVB_OFS_NORMAL = 8'h4A;
  localparam logic [7:0] BVB_OFS_STANDBY = 8'h4B;
  localparam logic [7:0] BVB_OFS_SLEEP = 8'h4C;
  localparam logic [7:0] BVB_OFS_MODE = 8'h4D;
  localparam logic [7:0] BVB_OFS_CONF = 8'h4E;
  localparam logic [7:0] BVB_OFS_BOOST = 8'h66;

  // setpoint register layout
  localparam int BVB_SP_RANGE_BIT = 6;
  localparam int BVB_SP_CODE_MSB = 5;
  localparam int BVB_MODE_FIELD_MSB = 3;

  // boost control layout
  localparam int BVB_BST_VOUT_LSB = 0;
  localparam int BVB_BST_NORM_LSB = 2;
  localparam int BVB_BST_STBY_LSB = 5;

  // reset values
  localparam logic BVB_RANGE_RST = 1'b0;
  localparam logic [5:0] BVB_SP_RST = 6'h00;
  localparam logic [7:0] BVB_MODE_RST = 8'h00;
  localparam logic [7:0] BVB_CONF_RST = 8'h00;
  localparam logic [1:0] BVB_BST_VOUT_RST = 2'h0;
  localparam logic [1:0] BVB_BST_MODE_RST = 2'h2;
  localparam logic BVB_TRACK_RST = 1'b0;
  localparam logic [4:0] BVB_SEQ_RST = 5'h00;

  // buck switching mode code forced while tracking
  localparam logic [3:0] BVB_BUCK_MODE_PWM = 4'h5;

  // voltage coding in millivolts
  localparam logic [11:0] BVB_LOW_BASE_MV = 12'h190;
  localparam logic [11:0] BVB_LOW_STEP_MV = 12'h019;
  localparam logic [11:0] BVB_HIGH_BASE_MV = 12'h320;
  localparam logic [11:0] BVB_HIGH_STEP_MV = 12'h032;
  localparam logic [5:0] BVB_HIGH_FIRST_RSVD = 6'h33;

  // i2c slave address, arbitrary value
  localparam logic [6:0] BVB_I2C_ADDR = 7'h08;

  typedef enum logic [1:0] {
    BVB_OP_NORMAL = 2'h0,
    BVB_OP_STANDBY = 2'h1,
    BVB_OP_SLEEP = 2'h2
  } bvb_op_state_t;

  typedef enum logic [1:0] {
    BVB_BST_OFF = 2'h0,
    BVB_BST_PFM = 2'h1,
    BVB_BST_AUTO = 2'h2,
    BVB_BST_APS = 2'h3
  } bvb_bst_mode_t;

  // one-time configuration image handed in by the otp / trial loader
  typedef struct packed {
    logic range_bit;
    logic tracking_select;
    logic [4:0] boost_sequence_slot;
  } bvb_otp_t;

  // one register write from the i2c engine
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } bvb_wr_t;

endpackage

// file: design/bvb_regs.sv
// buck channel four and boost control register bank with its i2c slave
// assumes scl/sda pins are open drain and resolved outside; otp loader,
// operating state and companion voltage come from logic on mclk
// Notes on behaviour
// - buck switching mode from 4-bit mode field
// - tracking reference is companion buck A times half
// - tracking forces fixed-PWM switching mode
// - otp tracking select bit picks tracking mode
// - setpoint range bit is read-only, set by config
// - low range 0.400 to 1.975 V, 25 mV steps
// - high range from 0.800 V, 50 mV steps
// - separate normal, standby, sleep setpoints applied per state
// - one range bit shared by all three setpoints
// - buck setpoints, mode and conf reachable over i2c; range and tracking set by otp only
// - boost joins power-up only with nonzero slot
// - boost output 5.000 to 5.150 V, resets 00
// - boost normal mode field, resets to automatic
// - boost standby mode field, same codes, automatic
// - automatic boost picks PULSE_FREQUENCY_MODE or pulse-skip by load
// - boost starts in automatic when sequenced
// - boost control bits 4 and 7 read zero
`timescale 1ns/1ps
`default_nettype none
module bvb_regs
  import bvb_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic otp_load,
  input wire bvb_otp_t otp_cfg,
  input wire bvb_op_state_t op_state,
  input wire logic [11:0] companion_a_mv,
  input wire logic boost_light_load,
  output logic [11:0] buck_ref_mv,
  output logic buck_ref_valid,
  output logic [3:0] buck_sw_mode,
  output logic buck_tracking,
  output logic [1:0] boost_vout_sel,
  output logic boost_enable,
  output bvb_bst_mode_t boost_run_mode,
  output logic boost_in_sequence
);

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_PTR = 9'h008,
    ST_PACK = 9'h010,
    ST_WR = 9'h020,
    ST_WACK = 9'h040,
    ST_RD = 9'h080,
    ST_RACK = 9'h100
  } bvb_i2c_st_t;

  // pin synchronisers and edge history
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic light_s1_q, light_s2_q;
  logic scl_rise, scl_fall, i2c_start, i2c_stop;

  bvb_i2c_st_t st_q;
  logic [7:0] shreg_q;
  logic [7:0] tx_q;
  logic [3:0] bitcnt_q;
  logic rw_q;
  logic [7:0] ptr_q;
  bvb_wr_t wr_q;
  logic [7:0] rdata;

  // register contents
  logic range_q;
  logic [5:0] sp_normal_q, sp_standby_q, sp_sleep_q;
  logic [7:0] mode_q;
  logic [7:0] conf_q;
  logic tracking_q;
  logic [4:0] seq_slot_q;
  logic [1:0] bst_vout_q;
  bvb_bst_mode_t bst_norm_q, bst_stby_q;

  logic [5:0] sp_sel;
  logic [11:0] dec_mv;
  logic dec_valid;
  bvb_bst_mode_t bst_sel;

  logic sda_out_q, sda_oe_n_q;
  logic [11:0] ref_mv_q;
  logic ref_valid_q;
  logic [3:0] sw_mode_q;
  logic track_out_q;
  logic [1:0] vout_out_q;
  logic bst_en_q;
  bvb_bst_mode_t run_mode_q;
  logic in_seq_q;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      light_s1_q <= 1'b0;
      light_s2_q <= 1'b0;
    end
    else
    begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      light_s1_q <= boost_light_load;
      light_s2_q <= light_s1_q;
    end
  end

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign i2c_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign i2c_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // readback mux; reserved and unmapped bits read zero
  always_comb
  begin
    case (ptr_q)
      BVB_OFS_NORMAL: rdata = {1'b0, range_q, sp_normal_q};
      BVB_OFS_STANDBY: rdata = {1'b0, range_q, sp_standby_q};
      BVB_OFS_SLEEP: rdata = {1'b0, range_q, sp_sleep_q};
      BVB_OFS_MODE: rdata = mode_q;
      BVB_OFS_CONF: rdata = conf_q;
      BVB_OFS_BOOST: rdata = {1'b0, bst_stby_q, 1'b0, bst_norm_q, bst_vout_q};
      default: rdata = 8'h00;
    endcase
  end

  // i2c byte engine; sda is changed only after scl falls
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= ST_IDLE;
      shreg_q <= 8'h00;
      tx_q <= 8'hFF;
      bitcnt_q <= 4'h0;
      rw_q <= 1'b0;
      ptr_q <= 8'h00;
      wr_q <= '0;
      sda_oe_n_q <= 1'b1;
    end
    else
    begin
      wr_q.en <= 1'b0;
      if (i2c_stop)
      begin
        st_q <= ST_IDLE;
        sda_oe_n_q <= 1'b1;
      end
      else if (i2c_start)
      begin
        st_q <= ST_ADDR;
        bitcnt_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end
      else if (scl_rise)
      begin
        case (st_q)
          ST_ADDR, ST_PTR, ST_WR:
          begin
            shreg_q <= {shreg_q[6:0], sda_s2_q};
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          ST_RACK: rw_q <= ~sda_s2_q;
          default: ;
        endcase
      end
      else if (scl_fall)
      begin
        case (st_q)
          ST_ADDR:
          begin
            if (bitcnt_q == 4'h8)
            begin
              if (shreg_q[7:1] == BVB_I2C_ADDR)
              begin
                st_q <= ST_AACK;
                rw_q <= shreg_q[0];
                sda_oe_n_q <= 1'b0;
              end
              else
              begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_AACK:
          begin
            bitcnt_q <= 4'h0;
            if (rw_q)
            begin
              st_q <= ST_RD;
              tx_q <= {rdata[6:0], 1'b1};
              sda_oe_n_q <= rdata[7];
            end
            else
            begin
              st_q <= ST_PTR;
              sda_oe_n_q <= 1'b1;
            end
          end
          ST_PTR:
          begin
            if (bitcnt_q == 4'h8)
            begin
              ptr_q <= shreg_q;
              st_q <= ST_PACK;
              sda_oe_n_q <= 1'b0;
            end
          end
          ST_WR:
          begin
            if (bitcnt_q == 4'h8)
            begin
              wr_q <= '{en: 1'b1, addr: ptr_q, data: shreg_q};
              ptr_q <= ptr_q + 8'h01;
              st_q <= ST_WACK;
              sda_oe_n_q <= 1'b0;
            end
          end
          ST_PACK, ST_WACK:
          begin
            st_q <= ST_WR;
            bitcnt_q <= 4'h0;
            sda_oe_n_q <= 1'b1;
          end
          ST_RD:
          begin
            if (bitcnt_q == 4'h7)
            begin
              st_q <= ST_RACK;
              ptr_q <= ptr_q + 8'h01;
              sda_oe_n_q <= 1'b1;
            end
            else
            begin
              bitcnt_q <= bitcnt_q + 4'h1;
              sda_oe_n_q <= tx_q[7];
              tx_q <= {tx_q[6:0], 1'b1};
            end
          end
          ST_RACK:
          begin
            // rw_q holds the master acknowledge here; a nack ends the read
            bitcnt_q <= 4'h0;
            if (rw_q)
            begin
              st_q <= ST_RD;
              tx_q <= {rdata[6:0], 1'b1};
              sda_oe_n_q <= rdata[7];
            end
            else
            begin
              st_q <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // one-time configuration; range is not writable over i2c
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      range_q <= BVB_RANGE_RST;
      tracking_q <= BVB_TRACK_RST;
      seq_slot_q <= BVB_SEQ_RST;
    end
    else if (otp_load)
    begin
      range_q <= otp_cfg.range_bit;
      tracking_q <= otp_cfg.tracking_select;
      seq_slot_q <= otp_cfg.boost_sequence_slot;
    end
  end

  // software registers; setpoint writes keep only the code bits
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sp_normal_q <= BVB_SP_RST;
      sp_standby_q <= BVB_SP_RST;
      sp_sleep_q <= BVB_SP_RST;
      mode_q <= BVB_MODE_RST;
      conf_q <= BVB_CONF_RST;
      bst_vout_q <= BVB_BST_VOUT_RST;
      bst_norm_q <= bvb_bst_mode_t'(BVB_BST_MODE_RST);
      bst_stby_q <= bvb_bst_mode_t'(BVB_BST_MODE_RST);
    end
    else if (wr_q.en)
    begin
      case (wr_q.addr)
        BVB_OFS_NORMAL: sp_normal_q <= wr_q.data[BVB_SP_CODE_MSB:0];
        BVB_OFS_STANDBY: sp_standby_q <= wr_q.data[BVB_SP_CODE_MSB:0];
        BVB_OFS_SLEEP: sp_sleep_q <= wr_q.data[BVB_SP_CODE_MSB:0];
        BVB_OFS_MODE: mode_q <= wr_q.data;
        BVB_OFS_CONF: conf_q <= wr_q.data;
        BVB_OFS_BOOST:
        begin
          bst_vout_q <= wr_q.data[BVB_BST_VOUT_LSB +: 2];
          bst_norm_q <= bvb_bst_mode_t'(wr_q.data[BVB_BST_NORM_LSB +: 2]);
          bst_stby_q <= bvb_bst_mode_t'(wr_q.data[BVB_BST_STBY_LSB +: 2]);
        end
        default: ;
      endcase
    end
  end

  // pick the setpoint for the present operating state
  always_comb
  begin
    case (op_state)
      BVB_OP_STANDBY: sp_sel = sp_standby_q;
      BVB_OP_SLEEP: sp_sel = sp_sleep_q;
      default: sp_sel = sp_normal_q;
    endcase
    bst_sel = (op_state == BVB_OP_NORMAL) ? bst_norm_q : bst_stby_q;
  end

  bvb_setpoint_decode u_decode (
    .range_bit(range_q),
    .code(sp_sel),
    .mv(dec_mv),
    .valid(dec_valid)
  );

  // buck channel outputs
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_mv_q <= 12'h000;
      ref_valid_q <= 1'b0;
      sw_mode_q <= 4'h0;
      track_out_q <= 1'b0;
    end
    else
    begin
      track_out_q <= tracking_q;
      if (tracking_q)
      begin
        ref_mv_q <= {1'b0, companion_a_mv[11:1]};
        ref_valid_q <= 1'b1;
        sw_mode_q <= BVB_BUCK_MODE_PWM;
      end
      else
      begin
        ref_mv_q <= dec_mv;
        ref_valid_q <= dec_valid;
        sw_mode_q <= mode_q[BVB_MODE_FIELD_MSB:0];
      end
    end
  end

  // boost outputs; automatic resolves against the load indication
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      vout_out_q <= BVB_BST_VOUT_RST;
      bst_en_q <= 1'b0;
      run_mode_q <= BVB_BST_OFF;
      in_seq_q <= 1'b0;
      sda_out_q <= 1'b0;
    end
    else
    begin
      vout_out_q <= bst_vout_q;
      in_seq_q <= (seq_slot_q != 5'h00);
      bst_en_q <= (bst_sel != BVB_BST_OFF);
      if (bst_sel == BVB_BST_AUTO)
        run_mode_q <= light_s2_q ? BVB_BST_PFM : BVB_BST_APS;
      else
        run_mode_q <= bst_sel;
      sda_out_q <= 1'b0;
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe_n = sda_oe_n_q;
  assign buck_ref_mv = ref_mv_q;
  assign buck_ref_valid = ref_valid_q;
  assign buck_sw_mode = sw_mode_q;
  assign buck_tracking = track_out_q;
  assign boost_vout_sel = vout_out_q;
  assign boost_enable = bst_en_q;
  assign boost_run_mode = run_mode_q;
  assign boost_in_sequence = in_seq_q;

endmodule
`default_nettype wire

// file: design/bvb_setpoint_decode.sv
// setpoint decoder: range bit and 6-bit code to millivolts
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module bvb_setpoint_decode
  import bvb_pkg::*;
(
  input wire logic range_bit,
  input wire logic [5:0] code,
  output logic [11:0] mv,
  output logic valid
);

  always_comb
  begin
    if (range_bit)
    begin
      mv = 12'(BVB_HIGH_BASE_MV + 12'(code) * BVB_HIGH_STEP_MV);
      valid = (code < BVB_HIGH_FIRST_RSVD);
    end
    else
    begin
      mv = 12'(BVB_LOW_BASE_MV + 12'(code) * BVB_LOW_STEP_MV);
      valid = 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: sim/bvb_i2c_host.sv
// i2c host model standing in for the processor on the register bus
// assumes the bench resolves sda as open drain with a pull-up
`timescale 1ns/1ps
`default_nettype none
module bvb_i2c_host
  import bvb_pkg::*;
(
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  // 8-clock phases, double the 4-clock minimum, so the 3-clock ack lag fits
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic hp(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic start();
    hp(1);
    sda_rel <= 1'b1;
    hp(8);
    scl <= 1'b1;
    hp(8);
    sda_rel <= 1'b0;
    hp(8);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hp(1);
    sda_rel <= 1'b0;
    hp(8);
    scl <= 1'b1;
    hp(8);
    sda_rel <= 1'b1;
    hp(8);
  endtask
  task automatic bit_io(input logic b, output logic r);
    hp(1);
    sda_rel <= b;
    hp(8);
    scl <= 1'b1;
    hp(8);
    r = sda_line;
    scl <= 1'b0;
  endtask
  // msb first, ninth bit is the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(m, a);
  endtask
  task automatic probe(input logic [6:0] adr, output logic a);
    logic [7:0] q;
    start();
    xfer({adr, 1'b0}, 1'b1, q, a);
    stop();
  endtask
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xfer({BVB_I2C_ADDR, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
  task automatic reg_rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    xfer({BVB_I2C_ADDR, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    start();
    xfer({BVB_I2C_ADDR, 1'b1}, 1'b1, q, a2);
    xfer(8'hFF, 1'b1, d, a3);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
endmodule
`default_nettype wire

// file: sim/bvb_regs_chk.sv
// port checker for the buck four / boost register bank
// bound into bvb_regs; one mclk domain, reset active low
`timescale 1ns/1ps
`default_nettype none
module bvb_regs_chk
  import bvb_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic otp_load,
  input wire bvb_otp_t otp_cfg,
  input wire logic [11:0] companion_a_mv,
  input wire logic [11:0] buck_ref_mv,
  input wire logic buck_ref_valid,
  input wire logic [3:0] buck_sw_mode,
  input wire logic buck_tracking,
  input wire bvb_bst_mode_t boost_run_mode,
  input wire logic boost_in_sequence
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  track_pwm_a: assert property (buck_tracking |-> buck_sw_mode == BVB_BUCK_MODE_PWM)
    else $error("mode not forced in tracking");
  track_ref_a: assert property (buck_tracking [*2] |->
    buck_ref_valid && buck_ref_mv == ($past(companion_a_mv) >> 1))
    else $error("tracking reference wrong");
  track_sel_a: assert property (otp_load |->
    ##2 buck_tracking == $past(otp_cfg.tracking_select, 2))
    else $error("tracking select not applied");
  seq_slot_a: assert property (otp_load |->
    ##2 boost_in_sequence == ($past(otp_cfg.boost_sequence_slot, 2) != 5'h00))
    else $error("sequence membership wrong");
  auto_res_a: assert property (boost_run_mode != BVB_BST_AUTO)
    else $error("auto mode left unresolved");
  rsvd_code_a: assert property (!buck_ref_valid |-> !buck_tracking)
    else $error("reserved flag in tracking");
  ref_grid_a: assert property (buck_ref_valid && !buck_tracking |->
    buck_ref_mv inside {[12'h190:12'hCE4]} && (buck_ref_mv - 12'h190) % 12'h019 == 12'h000)
    else $error("reference off the setpoint grid");
  sda_hold_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda moved while scl high");
  cover property (buck_tracking [*2]);
  cover property (!buck_ref_valid);
  cover property (boost_run_mode == BVB_BST_PFM);
endmodule
bind bvb_regs bvb_regs_chk u_chk (.mclk, .resetn, .scl_in, .sda_oe_n, .otp_load, .otp_cfg,
  .companion_a_mv, .buck_ref_mv, .buck_ref_valid, .buck_sw_mode, .buck_tracking,
  .boost_run_mode, .boost_in_sequence);
`default_nettype wire

// file: sim/tb.sv
// bench for the buck four / boost register bank
// i2c through the host model; otp, state and load inputs driven here
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bvb_pkg::*;
  logic mclk, resetn, otp_load, light, scl, host_sda, sda_out, sda_oe_n, ok;
  logic ref_ok, tracking, bst_en, in_seq;
  bvb_otp_t otp_cfg;
  bvb_op_state_t op_state;
  bvb_bst_mode_t run_mode;
  logic [11:0] comp_mv, ref_mv;
  logic [3:0] sw_mode;
  logic [1:0] vsel;
  logic [7:0] q;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  wire logic sda_line = host_sda & (sda_oe_n | sda_out);
  bvb_regs u_dut (.mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .otp_load(otp_load), .otp_cfg(otp_cfg),
    .op_state(op_state), .companion_a_mv(comp_mv), .boost_light_load(light),
    .buck_ref_mv(ref_mv), .buck_ref_valid(ref_ok), .buck_sw_mode(sw_mode),
    .buck_tracking(tracking), .boost_vout_sel(vsel), .boost_enable(bst_en),
    .boost_run_mode(run_mode), .boost_in_sequence(in_seq));
  bvb_i2c_host u_host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_rel(host_sda));
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] mv(input logic r, input logic [5:0] c);
    return r ? 16'h0320 + c * 16'h0032 : 16'h0190 + c * 16'h0019;
  endfunction
  task automatic settle();
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_host.reg_wr(p, d, ok);
    chk(ok, 1'b1);
    settle();
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    u_host.reg_rd(p, q, ok);
    chk({ok, q}, {1'b1, e});
  endtask
  task automatic set_in(input bvb_op_state_t s, input logic l);
    @(posedge mclk);
    op_state <= s;
    light <= l;
    settle();
  endtask
  task automatic load(input bvb_otp_t c);
    @(posedge mclk);
    otp_cfg <= c;
    otp_load <= 1'b1;
    @(posedge mclk);
    otp_load <= 1'b0;
    settle();
  endtask
  task automatic t_reset();
    chk(ref_mv, mv(1'b0, 6'h00));
    chk({ref_ok, tracking, sw_mode}, 6'h20);
    chk({vsel, bst_en, in_seq}, 4'h2);
    rd(BVB_OFS_BOOST, 8'h48);
    rd(BVB_OFS_NORMAL, 8'h00);
    chk(run_mode, BVB_BST_APS);
  endtask
  task automatic t_setpt();
    wr(BVB_OFS_NORMAL, 8'hFF);
    rd(BVB_OFS_NORMAL, 8'h3F);
    wr(BVB_OFS_STANDBY, 8'h09);
    wr(BVB_OFS_SLEEP, 8'h20);
    chk(ref_mv, mv(1'b0, 6'h3F));
    set_in(BVB_OP_STANDBY, 1'b0);
    chk(ref_mv, mv(1'b0, 6'h09));
    set_in(BVB_OP_SLEEP, 1'b0);
    chk(ref_mv, mv(1'b0, 6'h20));
    set_in(BVB_OP_NORMAL, 1'b0);
  endtask
  task automatic t_mode();
    wr(BVB_OFS_MODE, 8'h0A);
    chk(sw_mode, 4'hA);
    wr(BVB_OFS_CONF, 8'hA5);
    rd(BVB_OFS_CONF, 8'hA5);
    rd(8'h50, 8'h00);
    u_host.probe(7'h09, ok);
    chk(ok, 1'b1);
  endtask
  task automatic t_boost();
    wr(BVB_OFS_BOOST, 8'hFF);
    rd(BVB_OFS_BOOST, 8'h6F);
    chk({vsel, bst_en, run_mode}, 5'h1F);
    wr(BVB_OFS_BOOST, 8'h28);
    chk({vsel, run_mode}, {2'h0, BVB_BST_APS});
    set_in(BVB_OP_NORMAL, 1'b1);
    chk(run_mode, BVB_BST_PFM);
    set_in(BVB_OP_STANDBY, 1'b0);
    chk(run_mode, BVB_BST_PFM);
    wr(BVB_OFS_BOOST, 8'h00);
    chk({bst_en, run_mode}, 3'h0);
    set_in(BVB_OP_NORMAL, 1'b0);
    chk({bst_en, run_mode}, 3'h0);
  endtask
  task automatic t_otp();
    load({1'b1, 1'b1, 5'h03});
    chk({tracking, sw_mode, in_seq}, 6'h2B);
    chk(ref_mv, 16'h0258);
    @(posedge mclk);
    comp_mv <= 12'h708;
    settle();
    chk(ref_mv, 16'h0384);
    rd(BVB_OFS_STANDBY, 8'h49);
    rd(BVB_OFS_SLEEP, 8'h60);
    load({1'b1, 1'b0, 5'h00});
    chk({ref_ok, tracking, in_seq, sw_mode}, 7'h0A);
    set_in(BVB_OP_STANDBY, 1'b0);
    chk({ref_ok, ref_mv}, 16'h1000 | mv(1'b1, 6'h09));
    set_in(BVB_OP_NORMAL, 1'b0);
    // top of the high range, the last code before the reserved ones
    wr(BVB_OFS_NORMAL, 8'h32);
    chk({ref_ok, ref_mv}, 16'h1000 | mv(1'b1, 6'h32));
  endtask
  // a second reset must bring back the defaults that t_reset checks, the otp image included
  task automatic t_rst2();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    settle();
    t_reset();
  endtask
  initial
  begin
    resetn = 1'b0;
    otp_load = 1'b0;
    otp_cfg = '0;
    op_state = BVB_OP_NORMAL;
    comp_mv = 12'h4B1;
    light = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    settle();
    t_reset();
    t_setpt();
    t_mode();
    t_boost();
    t_otp();
    t_rst2();
    report_and_stop();
  end
endmodule
`default_nettype wire
